// >>> rtl/adcsq_pkg.sv
// constants, types and register map of the converter sequencer control
//
// How it works
// - flag sets per interval code: every sample, sequence end, 12 or 16 samples
// - one-slot sequence makes interval code 01 act like code 00
// - flag clears on a 0 write or when run goes from 0 to 1
// - internal-ref bit 0 takes reference from channel 3 negative pin
// - external reference always uses low-range gain trim, range select ignored
// - stop mode shuts converter down, aborts conversion, clears run
// - after stop mode idle until run set, then 20 converter clocks power-up
// - control, sequence address and slots readable always, writable only while run is 0
// - divider codes 000-100 give /16, then /32 /64 /128; low codes read 011
// - continuous bit 1 repeats sequence, 0 stops after last slot
// - interrupt request only when flag and its enable are both 1
// - acquisition extension applies only to slots with extension enable set
// - status bits 11:8 show last result location written
// - run starts; single mode clears it at sequence end, continuous keeps it
// - run written 0 stops after current conversion, or at once in power-up or extension
// - config select 1 reaches slot idx[2:0]; 0 reads result buffer idx[3:0]
// - port index increments after every data port read, and after a data port write only with config select 1
// - sequence address: buffer start 11:8, first slot 6:4, last slot 2:0 inclusive
// - slots reset to 0; bit 7 ext temp, 6..3 range/ext/align/diff, 2:0 channel
// - slots are circular: first above last wraps from 7 to 0
// - results start at buffer start location, advance, wrap 15 to 0
// - sample is 17 converter clocks, 3 acquisition; a conversion is 34
// - channel codes 110 and 111 force internal temperature mode
package adcsq_pkg;

  // register offsets
  localparam logic [7:0] STATUS_OFS = 8'h06;
  localparam logic [7:0] SEQADR_OFS = 8'h07;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] DATAPORT_OFS = 8'h09;

  // converter_status fields
  localparam int ST_IDX_LSB = 0;
  localparam int ST_CFGSEL_BIT = 4;
  localparam int ST_DAI_BIT = 5;
  localparam int ST_RUN_BIT = 6;
  localparam int ST_LASTWR_LSB = 8;

  // converter_control fields
  localparam int CT_ACQ_LSB = 0;
  localparam int CT_IRQEN_BIT = 5;
  localparam int CT_CONT_BIT = 6;
  localparam int CT_IREF_BIT = 7;
  localparam int CT_INTV_LSB = 10;
  localparam int CT_CLKDIV_LSB = 12;

  // sequence_address fields
  localparam int SQ_LAST_LSB = 0;
  localparam int SQ_FIRST_LSB = 4;
  localparam int SQ_BADD_LSB = 8;

  // configuration slot fields
  localparam int CF_CH_LSB = 0;
  localparam int CF_DIFF_BIT = 3;
  localparam int CF_ALIGN_BIT = 4;
  localparam int CF_ACQEN_BIT = 5;
  localparam int CF_RANGE_BIT = 6;
  localparam int CF_EXTT_BIT = 7;

  // values after reset, and the lowest divider code read back
  localparam logic [2:0] CLKDIV_RST = 3'h3;
  localparam logic [2:0] CLKDIV_MIN_READ = 3'h3;
  localparam logic [7:0] SLOT_RST = 8'h00;

  // counts in converter clocks; interval counts in samples
  localparam int POWERUP_CLKS = 20;
  localparam int ACQ_CLKS = 3;
  localparam int SAMPLE_CLKS = 17;
  localparam int CONV_CLKS = 34;
  localparam int EXT_STEP_CLKS = 16;
  localparam int INTV_COUNT_A = 12;
  localparam int INTV_COUNT_B = 16;

  typedef enum logic [1:0] {
    INTV_EVERY = 2'b00,
    INTV_SEQ   = 2'b01,
    INTV_12    = 2'b10,
    INTV_16    = 2'b11
  } adcsq_intv_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_POWERUP = 2'b01,
    ST_ACQEXT  = 2'b10,
    ST_CONVERT = 2'b11
  } adcsq_state_t;

endpackage

// >>> rtl/adcsq_result_mem.sv
// result buffer memory, cleared by reset, registered read data
`timescale 1ns/1ns
module adcsq_result_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  if (DEPTH > (1 << AW) || WIDTH < 1) begin : g_chk
    $error("adcsq_result_mem: depth does not fit address width");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] words;
    logic [WIDTH-1:0]            q;
  } adcsq_mem_t;

  adcsq_mem_t r;
  adcsq_mem_t next_r;

  // write port and read port; a read in the write cycle returns the old word
  always_comb begin
    next_r = r;
    if (we) begin
      next_r.words[waddr] = wdata;
    end
    if (re) begin
      next_r.q = r.words[raddr];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.q;

endmodule

// >>> rtl/adcsq_control.sv
// converter sequencer control: registers, clock divider, sequencing, result storage
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module adcsq_control import adcsq_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter int RES_W  = 13
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [DATA_W-1:0] bus_rdata,
  input  wire logic              stop_mode,
  input  wire logic [RES_W-1:0]  conv_result,
  output logic                   conv_powered,
  output logic                   conv_tick,
  output logic                   conv_sampling,
  output logic                   conv_done,
  output logic      [2:0]        channel_sel,
  output logic                   diff_input_sel,
  output logic                   ext_temp_sel,
  output logic                   int_temp_sel,
  output logic                   high_range_gain_sel,
  output logic                   ref_from_chan3_neg,
  output logic                   irq
);

  if (DATA_W != 16 || RES_W != 13 || ADDR_W < 4) begin : g_chk
    $error("adcsq_control: data must be 16 bits, results 13 bits");
  end

  typedef struct packed {
    logic [2:0]      clkdiv;
    logic [1:0]      intv;
    logic            iref;
    logic            cont;
    logic            irqen;
    logic [3:0]      acq;
    logic [3:0]      last_wr;
    logic            run;
    logic            dai;
    logic            cfgsel;
    logic [3:0]      idx;
    logic [3:0]      badd;
    logic [2:0]      first;
    logic [2:0]      last;
    logic [7:0][7:0] slots;
    adcsq_state_t    state;
    logic [2:0]      slot;
    logic [3:0]      wptr;
    logic [4:0]      smpcnt;
    logic            stop_req;
    logic [6:0]      divcnt;
    logic            tick;
    logic [8:0]      cnt;
    logic            done;
    logic            mem_we;
    logic [3:0]      mem_wa;
    logic [15:0]     mem_wd;
    logic [15:0]     rdq;
    logic            rd_buf;
  } adcsq_regs_t;

  adcsq_regs_t r;
  adcsq_regs_t next_r;

  logic        mem_re;
  logic [15:0] mem_q;
  logic [7:0]  cur;
  logic        dai_set;
  logic        seq_end;
  logic [4:0]  cnt_next;
  logic [2:0]  slot_next;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // last divider count for a divider code
  function automatic logic [6:0] div_last(input logic [2:0] code);
    unique case (code)
      3'h5:    div_last = 7'h1f;
      3'h6:    div_last = 7'h3f;
      3'h7:    div_last = 7'h7f;
      default: div_last = 7'h0f;
    endcase
  endfunction

  // extension length in converter clocks; high acq bits fold with slower dividers
  function automatic logic [8:0] ext_clks(input logic [3:0] acq, input logic [2:0] code);
    logic [3:0] m;
    m = 4'hf;
    unique case (code)
      3'h5:    m = 4'h7;
      3'h6:    m = 4'h3;
      3'h7:    m = 4'h1;
      default: m = 4'hf;
    endcase
    ext_clks = {({1'b0, acq & m} + 5'd1), 4'h0};
  endfunction

  // internal temperature mode from the channel code
  function automatic logic is_int_temp(input logic [7:0] cfg);
    is_int_temp = (cfg[CF_CH_LSB+1 +: 2] == 2'b11);
  endfunction

  // phase that opens a conversion for a slot
  function automatic adcsq_state_t open_phase(input logic [7:0] cfg);
    if (cfg[CF_ACQEN_BIT] && !is_int_temp(cfg) && !cfg[CF_EXTT_BIT]) begin
      open_phase = ST_ACQEXT;
    end else begin
      open_phase = ST_CONVERT;
    end
  endfunction

  // place a 13-bit result in the 16-bit word
  function automatic logic [15:0] align(input logic [12:0] res, input logic left);
    if (left) begin
      align = {res, 3'h0};
    end else begin
      align = {{3{res[12]}}, res};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  assign cur = r.slots[r.slot];
  assign seq_end = (r.slot == r.last);
  assign cnt_next = r.smpcnt + 5'd1;
  assign slot_next = seq_end ? r.first : r.slot + 3'd1;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    next_r.done = 1'b0;
    next_r.mem_we = 1'b0;
    next_r.rd_buf = 1'b0;
    next_r.rdq = '0;
    dai_set = 1'b0;

    // converter clock divider, held while idle
    if (r.state == ST_IDLE) begin
      next_r.divcnt = '0;
    end else if (r.divcnt == div_last(r.clkdiv)) begin
      next_r.divcnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.divcnt = r.divcnt + 7'd1;
    end

    // sequencing engine, advancing on converter clocks
    unique case (r.state)
      ST_IDLE: begin
      end
      ST_POWERUP: begin
        if (r.tick) begin
          if (r.cnt == 9'(POWERUP_CLKS - 1)) begin
            next_r.cnt = '0;
            next_r.state = open_phase(cur);
          end else begin
            next_r.cnt = r.cnt + 9'd1;
          end
        end
      end
      ST_ACQEXT: begin
        if (r.tick) begin
          if (r.cnt == ext_clks(r.acq, r.clkdiv) - 9'd1) begin
            next_r.cnt = '0;
            next_r.state = ST_CONVERT;
          end else begin
            next_r.cnt = r.cnt + 9'd1;
          end
        end
      end
      ST_CONVERT: begin
        if (r.tick) begin
          if (r.cnt == 9'(CONV_CLKS - 1)) begin
            next_r.cnt = '0;
            next_r.done = 1'b1;
            // store the aligned result and advance the buffer pointer
            next_r.mem_we = 1'b1;
            next_r.mem_wa = r.wptr;
            next_r.mem_wd = align(conv_result, cur[CF_ALIGN_BIT]);
            next_r.last_wr = r.wptr;
            next_r.wptr = r.wptr + 4'd1;
            // data-available interval
            next_r.smpcnt = cnt_next;
            unique case (adcsq_intv_t'(r.intv))
              INTV_EVERY: dai_set = 1'b1;
              INTV_SEQ:   dai_set = seq_end;
              INTV_12: begin
                dai_set = (cnt_next == 5'(INTV_COUNT_A));
              end
              INTV_16: begin
                dai_set = (cnt_next == 5'(INTV_COUNT_B));
              end
            endcase
            if (dai_set && r.intv[1]) begin
              next_r.smpcnt = '0;
            end else if (cnt_next == 5'(INTV_COUNT_B)) begin
              next_r.smpcnt = '0;
            end
            // next slot, sequence end, or stop
            next_r.slot = slot_next;
            if (r.stop_req) begin
              next_r.state = ST_IDLE;
              next_r.stop_req = 1'b0;
            end else if (seq_end && !r.cont) begin
              next_r.state = ST_IDLE;
              next_r.run = 1'b0;
            end else begin
              next_r.state = open_phase(r.slots[slot_next]);
            end
          end else begin
            next_r.cnt = r.cnt + 9'd1;
          end
        end
      end
    endcase

    // register writes
    if (bus_wr) begin
      unique case (bus_addr[3:0])
        STATUS_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(STATUS_OFS)) begin
            next_r.cfgsel = bus_wdata[ST_CFGSEL_BIT];
            next_r.idx = bus_wdata[ST_IDX_LSB +: 4];
            if (!bus_wdata[ST_DAI_BIT]) begin
              next_r.dai = 1'b0;
            end
            if (bus_wdata[ST_RUN_BIT] && !r.run && !stop_mode) begin
              // start a new sequence
              next_r.run = 1'b1;
              next_r.dai = 1'b0;
              next_r.smpcnt = '0;
              next_r.slot = r.first;
              next_r.wptr = r.badd;
              next_r.state = ST_POWERUP;
              next_r.cnt = '0;
              next_r.divcnt = '0;
              next_r.stop_req = 1'b0;
            end else if (!bus_wdata[ST_RUN_BIT] && r.run) begin
              next_r.run = 1'b0;
              if (r.state == ST_CONVERT) begin
                next_r.stop_req = 1'b1;
              end else begin
                next_r.state = ST_IDLE;
                next_r.cnt = '0;
              end
            end
          end
        end
        SEQADR_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(SEQADR_OFS) && !r.run) begin
            next_r.badd = bus_wdata[SQ_BADD_LSB +: 4];
            next_r.first = bus_wdata[SQ_FIRST_LSB +: 3];
            next_r.last = bus_wdata[SQ_LAST_LSB +: 3];
          end
        end
        CONTROL_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(CONTROL_OFS) && !r.run) begin
            next_r.clkdiv = bus_wdata[CT_CLKDIV_LSB +: 3];
            next_r.intv = bus_wdata[CT_INTV_LSB +: 2];
            next_r.iref = bus_wdata[CT_IREF_BIT];
            next_r.cont = bus_wdata[CT_CONT_BIT];
            next_r.irqen = bus_wdata[CT_IRQEN_BIT];
            next_r.acq = bus_wdata[CT_ACQ_LSB +: 4];
          end
        end
        DATAPORT_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(DATAPORT_OFS) && r.cfgsel) begin
            if (!r.run) begin
              next_r.slots[r.idx[2:0]] = bus_wdata[7:0];
            end
            next_r.idx = r.idx + 4'd1;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, answered in the next cycle
    if (bus_rd) begin
      unique case (bus_addr[3:0])
        STATUS_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(STATUS_OFS)) begin
            next_r.rdq[ST_LASTWR_LSB +: 4] = r.last_wr;
            next_r.rdq[ST_RUN_BIT] = r.run;
            next_r.rdq[ST_DAI_BIT] = r.dai;
            next_r.rdq[ST_CFGSEL_BIT] = r.cfgsel;
            next_r.rdq[ST_IDX_LSB +: 4] = r.idx;
          end
        end
        SEQADR_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(SEQADR_OFS)) begin
            next_r.rdq[SQ_BADD_LSB +: 4] = r.badd;
            next_r.rdq[SQ_FIRST_LSB +: 3] = r.first;
            next_r.rdq[SQ_LAST_LSB +: 3] = r.last;
          end
        end
        CONTROL_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(CONTROL_OFS)) begin
            next_r.rdq[CT_CLKDIV_LSB +: 3] = (r.clkdiv < CLKDIV_MIN_READ) ? CLKDIV_MIN_READ : r.clkdiv;
            next_r.rdq[CT_INTV_LSB +: 2] = r.intv;
            next_r.rdq[CT_IREF_BIT] = r.iref;
            next_r.rdq[CT_CONT_BIT] = r.cont;
            next_r.rdq[CT_IRQEN_BIT] = r.irqen;
            next_r.rdq[CT_ACQ_LSB +: 4] = r.acq;
          end
        end
        DATAPORT_OFS[3:0]: begin
          if (bus_addr == ADDR_W'(DATAPORT_OFS)) begin
            if (r.cfgsel) begin
              next_r.rdq[7:0] = r.slots[r.idx[2:0]];
            end else begin
              next_r.rd_buf = 1'b1;
            end
            next_r.idx = r.idx + 4'd1;
          end
        end
        default: begin
        end
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    if (dai_set) begin
      next_r.dai = 1'b1;
    end

    // stop mode: full shutdown and abort
    if (stop_mode) begin
      next_r.state = ST_IDLE;
      next_r.run = 1'b0;
      next_r.stop_req = 1'b0;
      next_r.cnt = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.clkdiv <= CLKDIV_RST;
      r.slots <= {8{SLOT_RST}};
      r.state <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result buffer

  assign mem_re = bus_rd && (bus_addr == ADDR_W'(DATAPORT_OFS)) && !r.cfgsel;

  adcsq_result_mem #(
    .WIDTH (16),
    .DEPTH (16),
    .AW    (4)
  ) u_mem (
    .mclk  (mclk),
    .rst_n (rst_n),
    .we    (r.mem_we),
    .waddr (r.mem_wa),
    .wdata (r.mem_wd),
    .re    (mem_re),
    .raddr (r.idx),
    .rdata (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus_rdata = r.rd_buf ? mem_q : r.rdq;
  assign irq = r.dai & r.irqen;
  assign conv_powered = (r.state != ST_IDLE);
  assign conv_tick = r.tick;
  assign conv_done = r.done;
  // acquisition: extension phase plus first 3 clocks of each 17-clock sample
  assign conv_sampling = (r.state == ST_ACQEXT)
                       | ((r.state == ST_CONVERT)
                          & ((r.cnt < 9'(ACQ_CLKS))
                             | ((r.cnt >= 9'(SAMPLE_CLKS)) & (r.cnt < 9'(SAMPLE_CLKS + ACQ_CLKS)))));
  assign channel_sel = cur[CF_CH_LSB +: 3];
  assign int_temp_sel = conv_powered & is_int_temp(cur);
  assign ext_temp_sel = conv_powered & cur[CF_EXTT_BIT] & ~is_int_temp(cur);
  // channel 3 positive pin stays single-ended while its negative pin is the reference
  assign diff_input_sel = cur[CF_DIFF_BIT] & ~is_int_temp(cur)
                        & ~(~r.iref & (cur[CF_CH_LSB +: 3] == 3'h3));
  assign high_range_gain_sel = r.iref & cur[CF_RANGE_BIT];
  assign ref_from_chan3_neg = ~r.iref;

endmodule

// >>> sim/adcsq_control_properties.sv
// assertion checker for the converter sequencer control ports
`timescale 1ns/1ns
module adcsq_control_props #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16,
  parameter int RES_W  = 13
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic              bus_wr,
  input wire logic              bus_rd,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic              stop_mode,
  input wire logic [RES_W-1:0]  conv_result,
  input wire logic              conv_powered,
  input wire logic              conv_tick,
  input wire logic              conv_sampling,
  input wire logic              conv_done,
  input wire logic [2:0]        channel_sel,
  input wire logic              diff_input_sel,
  input wire logic              ext_temp_sel,
  input wire logic              int_temp_sel,
  input wire logic              high_range_gain_sel,
  input wire logic              ref_from_chan3_neg,
  input wire logic              irq
);
  logic [7:0] tick_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // converter clocks since power-up, saturating, cleared while idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tick_cnt <= 8'h00;
    else if (!conv_powered) tick_cnt <= 8'h00;
    else if (conv_tick && tick_cnt != 8'hff) tick_cnt <= tick_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == '0)
    else $error("read data not zero outside read answer");
  AST_TICK_SPACING: assert property (conv_tick |=> !conv_tick [*8])
    else $error("converter clock faster than system clock by 16");
  AST_DONE_AFTER_POWERUP: assert property (conv_done |-> tick_cnt >= 8'h35)
    else $error("result before power-up and conversion clocks");
  AST_DONE_SPACING: assert property (conv_done |=> !conv_done [*8])
    else $error("conversion done pulses too close");
  AST_STOP_SHUTDOWN: assert property (stop_mode |-> ##[0:2] !conv_powered)
    else $error("converter still powered in stop mode");
  AST_SAMPLING_POWERED: assert property (conv_sampling |-> conv_powered && tick_cnt >= 8'd20)
    else $error("acquisition while converter idle");
  AST_INT_TEMP: assert property (int_temp_sel |-> channel_sel[2:1] == 2'b11 && !ext_temp_sel)
    else $error("internal temperature on wrong channel");
  AST_TEMP_FORCED: assert property (conv_powered && channel_sel[2:1] == 2'b11 |-> int_temp_sel)
    else $error("channel 6 or 7 not in temperature mode");
  AST_EXT_REF_LOW_RANGE: assert property (high_range_gain_sel |-> !ref_from_chan3_neg)
    else $error("high range trim with external reference");
  AST_EXT_REF_CHAN3: assert property (ref_from_chan3_neg && channel_sel == 3'h3 |-> !diff_input_sel)
    else $error("channel 3 differential with external reference");
endmodule
bind adcsq_control adcsq_control_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .RES_W(RES_W)) u_props (
  .mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .stop_mode(stop_mode), .conv_result(conv_result), .conv_powered(conv_powered),
  .conv_tick(conv_tick), .conv_sampling(conv_sampling), .conv_done(conv_done), .channel_sel(channel_sel),
  .diff_input_sel(diff_input_sel), .ext_temp_sel(ext_temp_sel), .int_temp_sel(int_temp_sel),
  .high_range_gain_sel(high_range_gain_sel), .ref_from_chan3_neg(ref_from_chan3_neg), .irq(irq));

// >>> sim/tb.sv
// self-checking testbench of the converter sequencer control
`timescale 1ns/1ns
module tb;
  import adcsq_pkg::*;
  logic        mclk, rst_n, bus_wr, bus_rd, stop_mode, conv_powered, conv_tick, conv_sampling, conv_done, irq;
  logic        diff_input_sel, ext_temp_sel, int_temp_sel, high_range_gain_sel, ref_from_chan3_neg;
  logic [7:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata, d;
  logic [12:0] conv_result;
  logic [2:0]  channel_sel;
  logic [7:0]  slot [8];
  int          errors, num_checks, seed, n, cyc;
  adcsq_control DUT (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .stop_mode(stop_mode), .conv_result(conv_result),
    .conv_powered(conv_powered), .conv_tick(conv_tick), .conv_sampling(conv_sampling), .conv_done(conv_done),
    .channel_sel(channel_sel), .diff_input_sel(diff_input_sel), .ext_temp_sel(ext_temp_sel),
    .int_temp_sel(int_temp_sel), .high_range_gain_sel(high_range_gain_sel),
    .ref_from_chan3_neg(ref_from_chan3_neg), .irq(irq));
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // compare, count and report
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the answer cycle
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  // wait for a result under a bounded count
  task automatic wait_done();
    cyc = 0;
    do begin
      @(posedge mclk);
      #1 cyc++;
    end while (conv_done !== 1'b1 && cyc < 20000);
    check("done_seen", 16'h0001, cyc < 20000);
  endtask
  // verdict
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog
  initial begin
    #6000000;
    errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 70567;
    errors = 0;
    num_checks = 0;
    {rst_n, bus_wr, bus_rd, stop_mode, bus_addr, bus_wdata, conv_result} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(STATUS_OFS); check("status_rst", 16'h0000, d);
    rd(SEQADR_OFS); check("seqadr_rst", 16'h0000, d);
    rd(CONTROL_OFS); check("control_rst", 16'h3000, d);
    rd(8'h0a); check("unmapped", 16'h0000, d);
    check("ref_rst", 16'h0001, ref_from_chan3_neg);
    // divider codes and their read-back
    for (int c = 0; c < 8; c++) begin
      wr(CONTROL_OFS, {1'b0, 3'(c), 12'hcef});
      rd(CONTROL_OFS); check("clkdiv", {1'b0, (c < 3) ? 3'h3 : 3'(c), 12'hcef}, d);
      check("ref_int", 16'h0000, ref_from_chan3_neg);
    end
    // random slot contents through the port, index advancing
    wr(STATUS_OFS, 16'h0010);
    rd(DATAPORT_OFS); check("slot_rst", 16'h0000, d);
    wr(STATUS_OFS, 16'h0010);
    for (int i = 0; i < 8; i++) begin
      slot[i] = 8'($random(seed));
      wr(DATAPORT_OFS, {8'h00, slot[i]});
    end
    rd(STATUS_OFS); check("idx_after_wr", 16'h0018, d);
    wr(STATUS_OFS, 16'h0010);
    for (int i = 0; i < 8; i++) begin
      rd(DATAPORT_OFS); check("slot", {8'h00, slot[i]}, d);
    end
    // port write with result buffer selected changes nothing
    wr(STATUS_OFS, 16'h0003);
    wr(DATAPORT_OFS, 16'h00aa);
    rd(STATUS_OFS); check("idx_kept", 16'h0003, d);
    rd(DATAPORT_OFS); check("buf_rst", 16'h0000, d);
    rd(STATUS_OFS); check("idx_rd_inc", 16'h0004, d);
    // slot 7 channel 3 differential, slot 0 channel 1; slot address idx[2:0] wraps 7 to 0
    wr(STATUS_OFS, 16'h0017);
    wr(DATAPORT_OFS, 16'h000b);
    wr(DATAPORT_OFS, 16'h0001);
    // single slot, interval every sample, divide by 32, external reference
    wr(CONTROL_OFS, 16'h5020);
    wr(SEQADR_OFS, 16'h0900);
    conv_result <= 13'($random(seed));
    wr(STATUS_OFS, 16'h0040);
    wait_done();
    check("time_div32", 16'h0001, cyc >= 53 * 32 && cyc <= 55 * 32);
    rd(STATUS_OFS); check("single_end", 16'h0920, d);
    check("irq_on", 16'h0001, irq);
    wr(STATUS_OFS, 16'h0009);
    #1 check("irq_clr", 16'h0000, irq);
    rd(DATAPORT_OFS); check("result", {{3{conv_result[12]}}, conv_result}, d);
    // two slots wrapping 7 to 0, buffer wrapping 15 to 0
    wr(CONTROL_OFS, 16'h3020);
    wr(SEQADR_OFS, 16'h0f70);
    wr(STATUS_OFS, 16'h0040);
    #1 check("chan3_ref", 16'h000c, {channel_sel, diff_input_sel, high_range_gain_sel});
    wait_done();
    rd(STATUS_OFS); check("first_sample", 16'h0f60, d);
    wr(SEQADR_OFS, 16'h0000);
    wait_done();
    rd(STATUS_OFS); check("seq_wrap", 16'h0020, d);
    rd(SEQADR_OFS); check("seqadr_locked", 16'h0f70, d);
    // continuous, flag after 12 or 16 samples, counter restarted by run
    for (int k = 0; k < 2; k++) begin
      wr(CONTROL_OFS, k ? 16'h3c40 : 16'h3840);
      wr(STATUS_OFS, 16'h0040);
      for (n = 1; n <= 12 + 4 * k; n++) begin
        @(posedge mclk) conv_result <= 13'($random(seed));
        wait_done();
        rd(STATUS_OFS); check("interval_flag", n == 12 + 4 * k, d[5]);
      end
      check("cont_run", 16'h0001, d[6]);
      check("irq_masked", 16'h0000, irq);
      wr(STATUS_OFS, 16'h0000);
      wait_done();
      repeat (3) @(posedge mclk);
      check("stop_after_conv", 16'h0000, conv_powered);
    end
    // stop mode during power-up, deliberately without finishing first
    wr(STATUS_OFS, 16'h0040);
    repeat (100) @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 check("stop_off", 16'h0000, conv_powered);
    rd(STATUS_OFS); check("stop_run", 16'h0000, d[6]);
    @(posedge mclk) stop_mode <= 1'b0;
    repeat (40) @(posedge mclk);
    #1 check("idle_after_stop", 16'h0000, conv_powered);
    // slot 7 with acquisition extension, code 1 adds 32 converter clocks at divide by 16
    wr(STATUS_OFS, 16'h0017);
    wr(DATAPORT_OFS, 16'h002b);
    wr(CONTROL_OFS, 16'h3c41);
    wr(STATUS_OFS, 16'h0040);
    wait_done();
    check("time_ext16", 16'h0001, cyc >= 85 * 16 && cyc <= 87 * 16);
    close_out();
  end
endmodule
